// ### src/rcms_defines.svh
// Timing constants and fixed encodings for the reset and clock mode selector
`ifndef RCMS_DEFINES_SVH
`define RCMS_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define POR_DELAY_US 2000
`define POR_DELAY_CYC ((`POR_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_CLK_LOW_US 1000
`define EXT_CLK_LOW_CYC ((`EXT_CLK_LOW_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_RESET_VAL 3'h0
`endif

// ### src/rcms_pkg.sv
// Types for the reset and clock mode selector
package rcms_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL_RC = 3'b000,
    MODE_NORMAL_EXT = 3'b001,
    MODE_EMULATION = 3'b010,
    MODE_FREQ_MEAS = 3'b011,
    MODE_SCAN_TEST = 3'b100
  } op_mode_t;
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_WAIT_PIN = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;
endpackage

// ### src/delay_counter.sv
// Clearable up counter that flags when a delay has elapsed
`timescale 1ns/1ps
module delay_counter #(
  parameter int unsigned COUNT = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic run,
  // Status
  output logic done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (restart) begin
      cnt_q <= '0;
    end else if (run && cnt_q != W'(COUNT)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign done = (cnt_q == W'(COUNT));
endmodule // delay_counter

// ### src/reset_clock_mode_select.sv
// Power-on reset sequencing and operating mode and clock source selection
`timescale 1ns/1ps
`include "rcms_defines.svh"
module reset_clock_mode_select #(
  parameter int unsigned POR_CYCLES = `POR_DELAY_CYC,
  parameter int unsigned EXT_LOW_CYCLES = `EXT_CLK_LOW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Board pins
  input wire logic ext_reset_n,
  input wire logic test_select_a,
  input wire logic test_select_b,
  input wire logic clock_test_pin,
  // Core side
  input wire logic sys_clk_level,
  input wire logic core_active,
  input wire logic sleep_req,
  // Outputs
  output logic core_reset_n,
  output logic [2:0] op_mode,
  output logic use_ext_clock,
  output logic scan_clock_en,
  output logic clock_test_out,
  output logic clock_test_oe,
  output logic sleep_allowed
);
  rcms_pkg::seq_state_t state_q;
  rcms_pkg::op_mode_t mode_q;
  logic por_done;
  logic ext_low_done;
  logic [15:0] age_q;

  function automatic rcms_pkg::op_mode_t decode_mode(input logic a, input logic b,
                                                      input logic low_held);
    if (!a && !b) begin
      decode_mode = rcms_pkg::MODE_SCAN_TEST;
    end else if (!a) begin
      decode_mode = rcms_pkg::MODE_FREQ_MEAS;
    end else if (!b) begin
      decode_mode = rcms_pkg::MODE_EMULATION;
    end else if (low_held) begin
      decode_mode = rcms_pkg::MODE_NORMAL_EXT;
    end else begin
      decode_mode = rcms_pkg::MODE_NORMAL_RC;
    end
  endfunction

  // Both external clock modes run from clock_test_pin; sleep is blocked in them
  function automatic logic ext_clocked(input rcms_pkg::op_mode_t m);
    ext_clocked = (m == rcms_pkg::MODE_NORMAL_EXT) || (m == rcms_pkg::MODE_EMULATION);
  endfunction

  // Power-on delay, counted from the first oscillator edge
  delay_counter #(.COUNT(POR_CYCLES)) u_por (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(1'b0),
    .run(1'b1),
    .done(por_done)
  );

  // Clock/test pin low window while the core is held in reset, before release
  delay_counter #(.COUNT(EXT_LOW_CYCLES)) u_extlow (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(state_q == rcms_pkg::ST_RUN || clock_test_pin),
    .run(state_q != rcms_pkg::ST_RUN),
    .done(ext_low_done)
  );

  // Reset sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rcms_pkg::ST_POR;
    end else begin
      case (state_q)
        rcms_pkg::ST_POR: begin
          if (por_done) begin
            state_q <= rcms_pkg::ST_WAIT_PIN;
          end
        end
        rcms_pkg::ST_WAIT_PIN: begin
          if (ext_reset_n) begin
            state_q <= rcms_pkg::ST_RUN;
          end
        end
        rcms_pkg::ST_RUN: begin
          if (!ext_reset_n) begin
            state_q <= rcms_pkg::ST_WAIT_PIN;
          end
        end
        default: begin
          state_q <= rcms_pkg::ST_POR;
        end
      endcase
    end
  end

  // Cycles since power-on, saturating; only the delay check reads it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hffff) begin
      age_q <= age_q + 16'h0001;
    end
  end

  // Mode latch, updated only while held in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= rcms_pkg::op_mode_t'(`MODE_RESET_VAL);
    end else if (state_q != rcms_pkg::ST_RUN) begin
      mode_q <= decode_mode(test_select_a, test_select_b, ext_low_done);
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_n <= 1'b0;
      op_mode <= `MODE_RESET_VAL;
      use_ext_clock <= 1'b0;
      scan_clock_en <= 1'b0;
      clock_test_out <= 1'b0;
      clock_test_oe <= 1'b0;
      sleep_allowed <= 1'b0;
    end else begin
      core_reset_n <= (state_q == rcms_pkg::ST_RUN) && ext_reset_n;
      op_mode <= mode_q;
      use_ext_clock <= ext_clocked(mode_q);
      scan_clock_en <= (mode_q == rcms_pkg::MODE_SCAN_TEST);
      clock_test_oe <= (mode_q == rcms_pkg::MODE_FREQ_MEAS) && core_active;
      clock_test_out <= (mode_q == rcms_pkg::MODE_FREQ_MEAS) && core_active && sys_clk_level;
      sleep_allowed <= sleep_req && !ext_clocked(mode_q);
    end
  end

  // Core out of reset only while running and pin high
  core_reset_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_RUN) |=> !core_reset_n) else $error("core left reset early");
  pin_low_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_reset_n |=> !core_reset_n) else $error("pin low did not reset core");
  por_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == rcms_pkg::ST_POR && !por_done) |=> state_q == rcms_pkg::ST_POR)
    else $error("power-on delay cut short");
  pin_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_POR && !ext_reset_n) |=> state_q == rcms_pkg::ST_WAIT_PIN)
    else $error("left reset with pin low");
  por_age_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_reset_n |-> {16'h0000, age_q} > POR_CYCLES) else $error("core out before delay");

  // Power-on delay end, then the pin decides
  sequence por_end_s;
    state_q == rcms_pkg::ST_POR && por_done;
  endsequence
  por_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    por_end_s |=> state_q == rcms_pkg::ST_WAIT_PIN) else $error("delay end not seen");

  // Orderly restart: wait state sees the pin high, and it stays high
  sequence release_seen_s;
    state_q == rcms_pkg::ST_WAIT_PIN && ext_reset_n;
  endsequence
  sequence pin_still_high_s;
    ext_reset_n;
  endsequence
  release_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    release_seen_s ##1 pin_still_high_s |=> core_reset_n) else $error("core not restarted");

  // Clock source follows the latched mode
  rc_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_q == rcms_pkg::MODE_NORMAL_RC) |=> !use_ext_clock) else $error("rc mode ext clk");
  ext_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_clocked(mode_q) |=> use_ext_clock) else $error("external clock not used");
  normal_rc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_RUN && test_select_a && test_select_b && !ext_low_done)
    |=> mode_q == rcms_pkg::MODE_NORMAL_RC) else $error("normal rc not chosen");
  sequence ext_window_s;
    state_q != rcms_pkg::ST_RUN && test_select_a && test_select_b && ext_low_done;
  endsequence
  normal_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_window_s |=> ##1 use_ext_clock) else $error("normal ext not chosen");
  emulation_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_RUN && test_select_a && !test_select_b)
    |=> mode_q == rcms_pkg::MODE_EMULATION) else $error("emulation not chosen");

  // Test modes on the clock/test pin
  scan_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_RUN && !test_select_a && !test_select_b)
    |=> ##1 scan_clock_en) else $error("scan test not chosen");
  scan_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scan_clock_en |-> !clock_test_oe) else $error("clock driven in scan test");
  freq_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != rcms_pkg::ST_RUN && !test_select_a && test_select_b)
    |=> mode_q == rcms_pkg::MODE_FREQ_MEAS) else $error("frequency mode not chosen");
  freq_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clock_test_oe |-> $past(mode_q) == rcms_pkg::MODE_FREQ_MEAS) else $error("bad clock out");
  freq_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_q == rcms_pkg::MODE_FREQ_MEAS && core_active) |=> clock_test_oe)
    else $error("clock not driven out");
  out_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clock_test_oe |-> !clock_test_out) else $error("clock out while not driving");

  // Sleep gating and mode hold
  sleep_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    use_ext_clock |-> !sleep_allowed) else $error("sleep with external clock");
  sleep_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sleep_req && !ext_clocked(mode_q)) |=> sleep_allowed) else $error("sleep request lost");
  mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == rcms_pkg::ST_RUN && $past(state_q) == rcms_pkg::ST_RUN) |-> $stable(mode_q))
    else $error("mode changed while running");
  mode_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_reset_n |-> op_mode == mode_q) else $error("mode output stale");
endmodule // reset_clock_mode_select

// ### dv/board_model.sv
// Board strapping, reset source and clock pin drive for the mode selector
`timescale 1ns/1ps
module board_model #(
  parameter int LOW = 10
) (
  // Clock and requests from the bench
  input wire logic sys_clk,
  input wire logic hold_rst,
  input wire logic [1:0] strap,
  input wire logic want_low,
  input wire logic short_low,
  // Board pins
  output logic ext_reset_n,
  output logic test_select_a,
  output logic test_select_b,
  output logic clock_test_pin
);
  int cnt = 0;
  always @(posedge sys_clk) cnt <= hold_rst ? 0 : cnt + 1;
  assign ext_reset_n = !hold_rst;
  // Select a grounded with select b high for frequency measurement
  assign {test_select_a, test_select_b} = strap;
  // Low past the release window, or only after release when short
  assign clock_test_pin = !(want_low && (!short_low || !hold_rst) && cnt < LOW + 5);
endmodule // board_model

// ### dv/test_reset_clock_mode_select.sv
// Self-checking bench for the reset and clock mode selector
`timescale 1ns/1ps
module test_reset_clock_mode_select;
  localparam int POR = 20;
  localparam int LOW = 10;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic hold_rst = 1;
  logic [1:0] strap = 2'b11;
  logic want_low = 0;
  logic short_low = 0;
  logic sys_clk_level = 0;
  logic sleep_req = 0;
  logic core_active = 1;
  logic ext_reset_n, test_select_a, test_select_b, clock_test_pin, core_reset_n;
  logic use_ext_clock, scan_clock_en, clock_test_out, clock_test_oe, sleep_allowed;
  logic [2:0] op_mode;
  logic [6:0] exp_q[$];
  logic [6:0] e;
  logic [6:0] drv;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  wire [6:0] seen = {op_mode, use_ext_clock, scan_clock_en, clock_test_oe, sleep_allowed};
  always #25 sys_clk = ~sys_clk;
  board_model #(.LOW(LOW)) i_board (.sys_clk(sys_clk), .hold_rst(hold_rst), .strap(strap),
    .want_low(want_low), .short_low(short_low), .ext_reset_n(ext_reset_n),
    .test_select_a(test_select_a), .test_select_b(test_select_b),
    .clock_test_pin(clock_test_pin));
  reset_clock_mode_select #(.POR_CYCLES(POR), .EXT_LOW_CYCLES(LOW)) i_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .ext_reset_n(ext_reset_n), .test_select_a(test_select_a),
    .test_select_b(test_select_b), .clock_test_pin(clock_test_pin),
    .sys_clk_level(sys_clk_level), .core_active(core_active), .sleep_req(sleep_req),
    .core_reset_n(core_reset_n), .op_mode(op_mode), .use_ext_clock(use_ext_clock),
    .scan_clock_en(scan_clock_en), .clock_test_out(clock_test_out),
    .clock_test_oe(clock_test_oe), .sleep_allowed(sleep_allowed));
  task automatic chk(input logic [6:0] got, input logic [6:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, want);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [6:0] expect_of(input logic [1:0] s, input logic low, input logic sl);
    logic [2:0] m;
    case (s)
      2'b11: m = low ? 3'h1 : 3'h0;
      2'b10: m = 3'h2;
      2'b01: m = 3'h3;
      default: m = 3'h4;
    endcase
    return {m, m == 3'h1 || m == 3'h2, m == 3'h4, m == 3'h3, sl && m != 3'h1 && m != 3'h2};
  endfunction
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  // Compare settled outputs against the oldest note
  always @(negedge sys_clk) begin
    if (exp_q.size() > 0) begin
      chk(seen, exp_q.pop_front());
    end
  end
  initial begin
    logic [1:0] tab_s[6] = '{2'b11, 2'b11, 2'b10, 2'b01, 2'b00, 2'b11};
    logic tab_l[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    int n;
    void'($urandom(32'h20a7_52b4));
    repeat (6) @(negedge sys_clk);
    rst_n = 1;
    for (int i = 0; i < 6; i++) begin
      strap = tab_s[i];
      want_low = tab_l[i];
      short_low = (i == 5);
      sleep_req = 1'($urandom);
      hold_rst = 1;
      // Odd passes repeat the power-on reset, passes 2 and 4 reset mid-run
      if (i % 2) begin
        rst_n = 0;
        @(negedge sys_clk);
        rst_n = 1;
      end
      repeat (POR + LOW + 4) @(negedge sys_clk);
      chk({6'h00, core_reset_n}, 7'h00);
      e = expect_of(strap, want_low && !short_low, sleep_req);
      // Select a low, select b high and the reset pin low: clock already driven out
      chk({6'h00, clock_test_oe}, {6'h00, e[1]});
      hold_rst = 0;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 10) begin
        @(negedge sys_clk);
        n++;
      end
      chk({6'h00, core_reset_n}, 7'h01);
      repeat (2) @(negedge sys_clk);
      exp_q.push_back(e);
      // Pins wander while running; the selection must not follow
      repeat (LOW + 8) begin
        @(negedge sys_clk);
        drv = {5'h00, e[1] && core_active, e[1] && core_active && sys_clk_level};
        chk({5'h00, clock_test_oe, clock_test_out}, drv);
        strap = 2'($urandom);
        sys_clk_level = 1'($urandom);
        core_active = 1'($urandom);
      end
      core_active = 1'b1;
      @(negedge sys_clk);
      exp_q.push_back(e);
      repeat (2) @(negedge sys_clk);
    end
    repeat (2) @(negedge sys_clk);
    stop_test();
  end
endmodule // test_reset_clock_mode_select
